// ---- inc/aofc_pkg.sv ----
// package with register map and field layout of the output format control block
package aofc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_CBSA = 12'h559;
  localparam logic [11:0] OFS_CBSB = 12'h55a;
  localparam logic [11:0] OFS_FMT = 12'h561;
  localparam logic [11:0] OFS_ORCLR = 12'h562;
  localparam logic [11:0] OFS_ORSTAT = 12'h563;
  localparam logic [11:0] OFS_CHSEL = 12'h564;
  localparam logic [11:0] OFS_RATE = 12'h56e;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h580;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h581;
  localparam logic [11:0] OFS_CTRL_BITS = 12'h582;
  localparam logic [7:0] RST_CBSA = 8'h00;
  localparam logic [7:0] RST_CBSB = 8'h01;
  localparam logic [7:0] RST_FMT = 8'h01;
  localparam logic [7:0] RST_ORCLR = 8'h00;
  localparam logic [7:0] RST_CHSEL = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h10;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [1:0] RST_CS = 2'h0;
  // field positions
  localparam int SEL_LO = 0;
  localparam int SEL_HI_POS = 4;
  localparam int INV_POS = 2;
  localparam int SWAP_POS = 0;
  localparam int RATE_POS = 4;
  // selector codes and offset binary format code
  localparam logic [2:0] SRC_ZERO = 3'h0;
  localparam logic [2:0] SRC_OVR = 3'h1;
  localparam logic [2:0] SRC_PEN0 = 3'h2;
  localparam logic [2:0] SRC_PEN1 = 3'h3;
  localparam logic [2:0] SRC_RES = 3'h4;
  localparam logic [1:0] FMT_OFFSET = 2'h0;
endpackage : aofc_pkg

// ---- core/aofc_top.sv ----
// output format control register bank and sample formatter
// Behaviour
// (R1) three-bit selector picks control bit: zero, overrange, penalty0, penalty1, resolution
// (R2) selector A upper field used when bits equal 3, lower when 2 or 3
// (R3) selector B applies for 1, 2 or 3 control bits, resets to overrange
// (R4) invert bit inverts samples; format 00 offset binary else two's complement
// (R5) overrange clear bit 1 holds that converter's overrange bit cleared
// (R6) read-only status shows one overrange bit per virtual converter
// (R7) channel swap bit exchanges the two converter channels at output
// (R8) rate bit 4: 0 high lane range, 1 low range, reset 1
// (R9) overrange status stays set until cleared by its clear bit
`timescale 1ns/1ps
module aofc_top #(
  parameter int SAMPLE_W = 14,
  parameter int NUM_VC = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // sample inputs, two's complement, same clock
  input wire logic [SAMPLE_W-1:0] samp_a,
  input wire logic [SAMPLE_W-1:0] samp_b,
  input wire logic samp_valid,
  // auxiliary flags per channel, overrange events per virtual converter
  input wire logic [1:0] ovr_in,
  input wire logic [1:0] pen0_in,
  input wire logic [1:0] fast_level_detect,
  input wire logic [1:0] variable_range_monitor,
  input wire logic [NUM_VC-1:0] vc_ovr_event,
  // formatted outputs
  output logic [SAMPLE_W-1:0] out_a,
  output logic [SAMPLE_W-1:0] out_b,
  output logic [2:0] ctrl_a,
  output logic [2:0] ctrl_b,
  output logic out_valid,
  output logic lane_rate_low,
  // interrupt
  output logic irq
);
  logic [7:0] cbsa_r, cbsa_nxt, cbsb_r, cbsb_nxt, fmt_r, fmt_nxt, orclr_r, orclr_nxt;
  logic [7:0] chsel_r, chsel_nxt, rate_r, rate_nxt, mask_r, mask_nxt;
  logic [1:0] cs_r, cs_nxt;
  logic [NUM_VC-1:0] ors_r, ors_nxt, ist_r, ist_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [SAMPLE_W-1:0] oa_r, oa_nxt, ob_r, ob_nxt;
  logic [2:0] ca_r, ca_nxt, cb_r, cb_nxt;
  logic ov_r, ov_nxt;

  // source mux for one channel
  function automatic logic pick(input logic [2:0] sel, input logic o, input logic p0,
                                input logic p1, input logic rs);
    case (sel)
      aofc_pkg::SRC_ZERO: pick = 1'b0; // see (R1)
      aofc_pkg::SRC_OVR: pick = o;
      aofc_pkg::SRC_PEN0: pick = p0;
      aofc_pkg::SRC_PEN1: pick = p1;
      aofc_pkg::SRC_RES: pick = rs;
      default: pick = 1'b0;
    endcase
  endfunction : pick

  // format one sample
  function automatic logic [SAMPLE_W-1:0] fmt_s(input logic [SAMPLE_W-1:0] s, input logic [7:0] f);
    logic [SAMPLE_W-1:0] v;
    v = f[aofc_pkg::INV_POS] ? ~s : s; // see (R4)
    if (f[1:0] == aofc_pkg::FMT_OFFSET)
    begin
      v[SAMPLE_W-1] = ~v[SAMPLE_W-1]; // see (R4)
    end
    fmt_s = v;
  endfunction : fmt_s

  // control bits for one channel, packed lsb first
  function automatic logic [2:0] cbits(input logic [1:0] cs, input logic [7:0] a, input logic [7:0] b,
                                       input logic o, input logic p0, input logic p1, input logic rs);
    logic [2:0] c;
    c = 3'h0;
    if (cs != 2'h0)
    begin
      c[0] = pick(b[2:0], o, p0, p1, rs); // see (R3)
    end
    if (cs >= 2'h2)
    begin
      c[1] = pick(a[2:0], o, p0, p1, rs); // see (R2)
    end
    if (cs == 2'h3)
    begin
      c[2] = pick(a[6:4], o, p0, p1, rs); // see (R2)
    end
    cbits = c;
  endfunction : cbits

  // register writes, status and datapath next values
  always_comb
  begin
    logic [NUM_VC-1:0] wclr;
    wclr = '0;
    cbsa_nxt = cbsa_r;
    cbsb_nxt = cbsb_r;
    fmt_nxt = fmt_r;
    orclr_nxt = orclr_r;
    chsel_nxt = chsel_r;
    rate_nxt = rate_r;
    mask_nxt = mask_r;
    cs_nxt = cs_r;
    rdata_nxt = 8'h00;
    if (reg_wr)
    begin
      case (reg_addr)
        aofc_pkg::OFS_CBSA: cbsa_nxt = {1'b0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
        aofc_pkg::OFS_CBSB: cbsb_nxt = {5'h00, reg_wdata[2:0]};
        aofc_pkg::OFS_FMT: fmt_nxt = {5'h00, reg_wdata[2:0]};
        aofc_pkg::OFS_ORCLR: orclr_nxt = reg_wdata;
        aofc_pkg::OFS_CHSEL: chsel_nxt = {7'h00, reg_wdata[0]};
        aofc_pkg::OFS_RATE: rate_nxt = {3'h0, reg_wdata[4], 4'h0};
        aofc_pkg::OFS_IRQ_STAT: wclr = reg_wdata[NUM_VC-1:0];
        aofc_pkg::OFS_IRQ_MASK: mask_nxt = reg_wdata;
        aofc_pkg::OFS_CTRL_BITS: cs_nxt = reg_wdata[1:0];
        default: ;
      endcase
    end
    // sticky overrange status, set wins unless clear bit held
    ors_nxt = (ors_r | vc_ovr_event) & ~orclr_r[NUM_VC-1:0]; // see (R5) see (R9)
    // interrupt status: set wins over write-one-clear
    ist_nxt = (ist_r & ~wclr) | (vc_ovr_event & ~orclr_r[NUM_VC-1:0]);
    if (reg_rd)
    begin
      case (reg_addr)
        aofc_pkg::OFS_CBSA: rdata_nxt = cbsa_r;
        aofc_pkg::OFS_CBSB: rdata_nxt = cbsb_r;
        aofc_pkg::OFS_FMT: rdata_nxt = fmt_r;
        aofc_pkg::OFS_ORCLR: rdata_nxt = orclr_r;
        aofc_pkg::OFS_ORSTAT: rdata_nxt = ors_r; // see (R6)
        aofc_pkg::OFS_CHSEL: rdata_nxt = chsel_r;
        aofc_pkg::OFS_RATE: rdata_nxt = rate_r;
        aofc_pkg::OFS_IRQ_STAT: rdata_nxt = ist_r;
        aofc_pkg::OFS_IRQ_MASK: rdata_nxt = mask_r;
        aofc_pkg::OFS_CTRL_BITS: rdata_nxt = {6'h00, cs_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
    // datapath with optional channel swap
    ov_nxt = samp_valid;
    oa_nxt = fmt_s(chsel_r[aofc_pkg::SWAP_POS] ? samp_b : samp_a, fmt_r); // see (R7)
    ob_nxt = fmt_s(chsel_r[aofc_pkg::SWAP_POS] ? samp_a : samp_b, fmt_r); // see (R7)
    ca_nxt = cbits(cs_r, cbsa_r, cbsb_r, ovr_in[0], pen0_in[0], fast_level_detect[0], variable_range_monitor[0]);
    cb_nxt = cbits(cs_r, cbsa_r, cbsb_r, ovr_in[1], pen0_in[1], fast_level_detect[1], variable_range_monitor[1]);
    if (chsel_r[aofc_pkg::SWAP_POS])
    begin
      ca_nxt = cbits(cs_r, cbsa_r, cbsb_r, ovr_in[1], pen0_in[1], fast_level_detect[1], variable_range_monitor[1]);
      cb_nxt = cbits(cs_r, cbsa_r, cbsb_r, ovr_in[0], pen0_in[0], fast_level_detect[0], variable_range_monitor[0]);
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cbsa_r <= aofc_pkg::RST_CBSA;
      cbsb_r <= aofc_pkg::RST_CBSB; // see (R3)
      fmt_r <= aofc_pkg::RST_FMT; // see (R4)
      orclr_r <= aofc_pkg::RST_ORCLR;
      chsel_r <= aofc_pkg::RST_CHSEL;
      rate_r <= aofc_pkg::RST_RATE; // see (R8)
      mask_r <= aofc_pkg::RST_MASK;
      cs_r <= aofc_pkg::RST_CS;
      ors_r <= '0;
      ist_r <= '0;
      rdata_r <= 8'h00;
      oa_r <= '0;
      ob_r <= '0;
      ca_r <= 3'h0;
      cb_r <= 3'h0;
      ov_r <= 1'b0;
    end
    else
    begin
      cbsa_r <= cbsa_nxt;
      cbsb_r <= cbsb_nxt;
      fmt_r <= fmt_nxt;
      orclr_r <= orclr_nxt;
      chsel_r <= chsel_nxt;
      rate_r <= rate_nxt;
      mask_r <= mask_nxt;
      cs_r <= cs_nxt;
      ors_r <= ors_nxt;
      ist_r <= ist_nxt;
      rdata_r <= rdata_nxt;
      oa_r <= oa_nxt;
      ob_r <= ob_nxt;
      ca_r <= ca_nxt;
      cb_r <= cb_nxt;
      ov_r <= ov_nxt;
    end
  end

  // outputs
  assign reg_rdata = rdata_r;
  assign out_a = oa_r;
  assign out_b = ob_r;
  assign ctrl_a = ca_r;
  assign ctrl_b = cb_r;
  assign out_valid = ov_r;
  assign lane_rate_low = rate_r[aofc_pkg::RATE_POS]; // see (R8)
  assign irq = |(ist_r & mask_r[NUM_VC-1:0]);

  // checks on sticky overrange status and its clear bits
  AST_OVR_STICKY: assert property (@(posedge clk) disable iff (!rst_b) // see (R9)
    ors_r[0] && !orclr_r[0] |=> ors_r[0])
    else $error("overrange bit dropped");
  AST_OVR_STICKY_HI: assert property (@(posedge clk) disable iff (!rst_b) // see (R9)
    ors_r[7] && !orclr_r[7] |=> ors_r[7])
    else $error("upper overrange bit dropped");
  AST_OVR_SET: assert property (@(posedge clk) disable iff (!rst_b) // see (R6)
    vc_ovr_event[0] && !orclr_r[0] |=> ors_r[0])
    else $error("overrange not set");
  AST_OVR_CLR: assert property (@(posedge clk) disable iff (!rst_b) // see (R5)
    orclr_r[1] |=> !ors_r[1])
    else $error("cleared bit still set");
  AST_OVR_CLR_HI: assert property (@(posedge clk) disable iff (!rst_b) // see (R5)
    orclr_r[7] |=> !ors_r[7])
    else $error("upper cleared bit still set");
  AST_STAT_READ: assert property (@(posedge clk) disable iff (!rst_b) // see (R6)
    reg_rd && reg_addr == aofc_pkg::OFS_ORSTAT |=> reg_rdata == $past(ors_r))
    else $error("status read wrong");
  AST_STAT_RO: assert property (@(posedge clk) disable iff (!rst_b) // see (R6)
    reg_wr && reg_addr == aofc_pkg::OFS_ORSTAT && !vc_ovr_event[0] && !orclr_r[0] |=> ors_r[0] == $past(ors_r[0]))
    else $error("status written");

  // checks on the read port and the interrupt status
  AST_RD_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_IST_SET: assert property (@(posedge clk) disable iff (!rst_b)
    vc_ovr_event[0] && !orclr_r[0] |=> ist_r[0])
    else $error("interrupt status not set");
  AST_IST_CLR: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == aofc_pkg::OFS_IRQ_STAT && reg_wdata[0] && !vc_ovr_event[0] |=> !ist_r[0])
    else $error("interrupt status not cleared");

  // checks on sample order, number format and valid
  AST_SWAP: assert property (@(posedge clk) disable iff (!rst_b) // see (R7)
    chsel_r[0] && fmt_r == 8'h01 |=> out_a == $past(samp_b))
    else $error("swap wrong");
  AST_SWAP_B: assert property (@(posedge clk) disable iff (!rst_b) // see (R7)
    chsel_r[0] && fmt_r == 8'h01 |=> out_b == $past(samp_a))
    else $error("swap wrong on second channel");
  AST_NOSWAP: assert property (@(posedge clk) disable iff (!rst_b) // see (R7)
    !chsel_r[0] && fmt_r == 8'h01 |=> out_a == $past(samp_a))
    else $error("order wrong");
  AST_NOSWAP_B: assert property (@(posedge clk) disable iff (!rst_b) // see (R7)
    !chsel_r[0] && fmt_r == 8'h01 |=> out_b == $past(samp_b))
    else $error("order wrong on second channel");
  AST_INV: assert property (@(posedge clk) disable iff (!rst_b) // see (R4)
    !chsel_r[0] && fmt_r == 8'h05 |=> out_a == ~$past(samp_a))
    else $error("invert wrong");
  AST_OFFSET: assert property (@(posedge clk) disable iff (!rst_b) // see (R4)
    !chsel_r[0] && fmt_r == 8'h00 |=> out_a == {~$past(samp_a[SAMPLE_W-1]), $past(samp_a[SAMPLE_W-2:0])})
    else $error("offset binary wrong");
  AST_VALID: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> out_valid == $past(samp_valid))
    else $error("valid not delayed");

  // checks on control bit placement and selector codes
  AST_CS0: assert property (@(posedge clk) disable iff (!rst_b) // see (R3)
    cs_r == 2'h0 |=> ctrl_a == 3'h0)
    else $error("control bits not zero");
  AST_CSOVR: assert property (@(posedge clk) disable iff (!rst_b) // see (R1)
    cs_r == 2'h1 && cbsb_r == 8'h01 && !chsel_r[0] |=> ctrl_a[0] == $past(ovr_in[0]))
    else $error("overrange bit not routed");
  AST_CSOVR_B: assert property (@(posedge clk) disable iff (!rst_b) // see (R3)
    cs_r == 2'h1 && cbsb_r == 8'h01 && !chsel_r[0] |=> ctrl_b[0] == $past(ovr_in[1]))
    else $error("second overrange bit not routed");
  AST_SWAP_CTRL: assert property (@(posedge clk) disable iff (!rst_b) // see (R7)
    cs_r == 2'h1 && cbsb_r == 8'h01 && chsel_r[0] |=> ctrl_a[0] == $past(ovr_in[1]))
    else $error("flags not swapped");
  AST_CS1: assert property (@(posedge clk) disable iff (!rst_b) // see (R2)
    cs_r == 2'h1 |=> ctrl_a[2:1] == 2'h0)
    else $error("upper bits used at one");
  AST_CS2: assert property (@(posedge clk) disable iff (!rst_b) // see (R2)
    cs_r == 2'h2 |=> !ctrl_a[2])
    else $error("top bit used at two");
  AST_CS3_TOP: assert property (@(posedge clk) disable iff (!rst_b) // see (R2)
    cs_r == 2'h3 && cbsa_r[6:4] == aofc_pkg::SRC_OVR && !chsel_r[0] |=> ctrl_a[2] == $past(ovr_in[0]))
    else $error("top bit not routed");
  AST_SEL_ZERO: assert property (@(posedge clk) disable iff (!rst_b) // see (R1)
    cs_r != 2'h0 && cbsb_r[2:0] == aofc_pkg::SRC_ZERO |=> !ctrl_a[0] && !ctrl_b[0])
    else $error("zero code not zero");
  AST_SEL_PEN0: assert property (@(posedge clk) disable iff (!rst_b) // see (R1)
    cs_r != 2'h0 && cbsb_r[2:0] == aofc_pkg::SRC_PEN0 && !chsel_r[0] |=> ctrl_a[0] == $past(pen0_in[0]))
    else $error("penalty bit not routed");
  AST_SEL_FLD: assert property (@(posedge clk) disable iff (!rst_b) // see (R1)
    cs_r != 2'h0 && cbsb_r[2:0] == aofc_pkg::SRC_PEN1 && !chsel_r[0]
      |=> ctrl_a[0] == $past(fast_level_detect[0]))
    else $error("fast detect bit not routed");
  AST_SEL_VRM: assert property (@(posedge clk) disable iff (!rst_b) // see (R1)
    cs_r != 2'h0 && cbsb_r[2:0] == aofc_pkg::SRC_RES && !chsel_r[0]
      |=> ctrl_a[0] == $past(variable_range_monitor[0]))
    else $error("resolution bit not routed");

  // checks on the lane range output
  AST_RATE: assert property (@(posedge clk) disable iff (!rst_b) // see (R8)
    reg_wr && reg_addr == aofc_pkg::OFS_RATE |=> lane_rate_low == $past(reg_wdata[4]))
    else $error("rate bit wrong");
  AST_RATE_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // see (R8)
    !(reg_wr && reg_addr == aofc_pkg::OFS_RATE) |=> $stable(lane_rate_low))
    else $error("rate bit moved");
endmodule : aofc_top

// ---- bench/aofc_rx_model.sv ----
// behavioural link receiver that captures formatted samples
`timescale 1ns/1ps
module aofc_rx_model #(
  parameter int SAMPLE_W = 14
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // formatted stream
  input wire logic [SAMPLE_W-1:0] out_a,
  input wire logic [SAMPLE_W-1:0] out_b,
  input wire logic [2:0] ctrl_a,
  input wire logic out_valid,
  // last captured word
  output logic [SAMPLE_W-1:0] rx_a,
  output logic [SAMPLE_W-1:0] rx_b,
  output logic [2:0] rx_ctrl
);
  // take a word on every valid cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_a <= '0;
      rx_b <= '0;
      rx_ctrl <= '0;
    end
    else if (out_valid)
    begin
      rx_a <= out_a;
      rx_b <= out_b;
      rx_ctrl <= ctrl_a;
    end
  end
endmodule : aofc_rx_model

// ---- bench/adc_output_format_control_test.sv ----
// self-checking bench for the output format control block
`timescale 1ns/1ps
module adc_output_format_control_test;
  logic clk, rst_b, reg_wr, reg_rd, samp_valid, out_valid, lane_rate_low, irq;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, vc_ovr_event;
  logic [13:0] samp_a, samp_b, out_a, out_b, rx_a, rx_b;
  logic [1:0] ovr_in, pen0_in, fld, vrm;
  logic [2:0] ctrl_a, ctrl_b, rx_ctrl;
  int miscompares = 0;
  int samples_checked = 0;
  // device and far-side receiver
  aofc_top #(.SAMPLE_W(14), .NUM_VC(8)) i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .samp_a(samp_a),
    .samp_b(samp_b), .samp_valid(samp_valid), .ovr_in(ovr_in), .pen0_in(pen0_in), .fast_level_detect(fld),
    .variable_range_monitor(vrm), .vc_ovr_event(vc_ovr_event), .out_a(out_a), .out_b(out_b),
    .ctrl_a(ctrl_a), .ctrl_b(ctrl_b), .out_valid(out_valid), .lane_rate_low(lane_rate_low), .irq(irq));
  aofc_rx_model #(.SAMPLE_W(14)) i_rx (.clk(clk), .rst_b(rst_b), .out_a(out_a), .out_b(out_b),
    .ctrl_a(ctrl_a), .out_valid(out_valid), .rx_a(rx_a), .rx_b(rx_b), .rx_ctrl(rx_ctrl));
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one-cycle register write
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // one-cycle read, data judged in the following cycle
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, "reg_rdata");
  endtask : rd_chk
  // drive a sample pair and judge what the receiver got
  task automatic smp(input logic [13:0] a, b, ea, eb);
    @(posedge clk);
    samp_a <= a;
    samp_b <= b;
    repeat (3) @(posedge clk);
    #1;
    chk(rx_a, ea, "rx_a");
    chk(rx_b, eb, "rx_b");
  endtask : smp
  // one-cycle overrange event
  task automatic ev(input logic [7:0] d);
    @(posedge clk);
    vc_ovr_event <= d;
    @(posedge clk);
    vc_ovr_event <= 8'h00;
  endtask : ev
  // reset values, unmapped address and rate output
  task automatic t_reset;
    logic [11:0] ad [8] = '{12'h559, 12'h55a, 12'h561, 12'h562, 12'h563, 12'h564, 12'h56e, 12'h5ff};
    logic [7:0] ex [8] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
    for (int i = 0; i < 8; i++)
      rd_chk(ad[i], ex[i]);
    chk(lane_rate_low, 1'b1, "lane_rate_low");
    chk(out_valid, 1'b1, "out_valid");
  endtask : t_reset
  // number format, invert and channel swap
  task automatic t_format;
    smp(14'h0005, 14'h2000, 14'h0005, 14'h2000);
    wr(12'h561, 8'h00);
    smp(14'h0005, 14'h2000, 14'h2005, 14'h0000);
    wr(12'h561, 8'h05);
    smp(14'h0005, 14'h2000, 14'h3ffa, 14'h1fff);
    wr(12'h561, 8'h04);
    smp(14'h0005, 14'h2000, 14'h1ffa, 14'h3fff);
    wr(12'h564, 8'h01);
    smp(14'h0005, 14'h2000, 14'h3fff, 14'h1ffa);
    wr(12'h564, 8'h00);
    smp(14'h0005, 14'h2000, 14'h1ffa, 14'h3fff);
    wr(12'h561, 8'h01);
  endtask : t_format
  // every selector code with three control bits, then one bit
  task automatic t_ctrl;
    wr(12'h582, 8'h03);
    for (logic [2:0] c = 3'h0; c < 3'h5; c++)
    begin
      wr(12'h559, {1'b0, c, 1'b0, c});
      wr(12'h55a, {5'h00, c});
      ovr_in <= {1'b0, c == 3'h1};
      pen0_in <= {1'b0, c == 3'h2};
      fld <= {1'b0, c == 3'h3};
      vrm <= {1'b0, c == 3'h4};
      repeat (3) @(posedge clk);
      #1;
      chk(rx_ctrl, (c == 3'h0) ? 3'h0 : 3'h7, "ctrl_a");
      chk(ctrl_b, 3'h0, "ctrl_b");
    end
    wr(12'h582, 8'h01);
    repeat (3) @(posedge clk);
    #1;
    chk(ctrl_a, 3'h1, "ctrl_a");
  endtask : t_ctrl
  // sticky overrange, clear, read-only status and interrupt
  task automatic t_ovr;
    wr(12'h581, 8'hff);
    ev(8'h08);
    rd_chk(12'h563, 8'h08);
    wr(12'h563, 8'h00);
    rd_chk(12'h563, 8'h08);
    chk(irq, 1'b1, "irq");
    wr(12'h562, 8'h08);
    rd_chk(12'h563, 8'h00);
    ev(8'h08);
    rd_chk(12'h563, 8'h00);
    wr(12'h562, 8'h00);
    wr(12'h580, 8'hff);
    #1;
    chk(irq, 1'b0, "irq");
    wr(12'h581, 8'h00);
    ev(8'h81);
    rd_chk(12'h563, 8'h81);
    chk(irq, 1'b0, "irq");
  endtask : t_ovr
  // lane range select
  task automatic t_rate;
    wr(12'h56e, 8'h00);
    rd_chk(12'h56e, 8'h00);
    chk(lane_rate_low, 1'b0, "lane_rate_low");
  endtask : t_rate
  // verdict
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // main sequence
  initial
  begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, vc_ovr_event} = '0;
    {samp_a, samp_b, ovr_in, pen0_in, fld, vrm} = '0;
    samp_valid = 1'b1;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_format();
    t_ctrl();
    t_ovr();
    t_rate();
    end_of_test();
  end
endmodule : adc_output_format_control_test
